// ---- rtl/phy_link_carrier_control.v ----
`include "phy_link_map.vh"
module phy_link_carrier_control #(
  parameter LOCK_CYC = `LOCK_MS * (`CLK_HZ / 1000),
  parameter WIN_CYC = `WIN_MS * (`CLK_HZ / 1000),
  parameter SIL_CYC = `SIL_MS * (`CLK_HZ / 1000),
  parameter LP_TO_CYC = `LP_TO_MS * (`CLK_HZ / 1000),
  parameter JAB_TX = `JAB_TX_DEF,
  parameter UNJAB_TX = `UNJAB_TX_DEF
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Negotiation results, same clock.
  input wire an_complete,
  input wire an_speed100,
  input wire an_full_duplex,
  // Line and MII inputs from other clock domains.
  input wire rx_clk,
  input wire tx_clk,
  input wire tx_en,
  input wire [3:0] txd,
  input wire [4:0] rx_sym,
  input wire rx10_act,
  input wire [3:0] rx10_nib,
  input wire [2:0] rx10_drib,
  input wire lp_pulse,
  input wire lp_inv,
  input wire eof_inv,
  // MII receive outputs.
  output reg crs,
  output reg rx_dv,
  output reg [3:0] rxd,
  output reg rx_er,
  output reg col,
  // Line control outputs.
  output reg tx_data_en,
  output reg flp_send,
  output reg lp_send,
  output reg scr_en,
  output reg [10:0] scr_seed,
  output reg link_up,
  output reg an_restart,
  output reg pol_fix100
);
  localparam S_IDLE = 4'b0001;
  localparam S_J = 4'b0010;
  localparam S_FRM = 4'b0100;
  localparam S_T = 4'b1000;
  localparam T_IDLE = 5'b00001;
  localparam T_PRE = 5'b00010;
  localparam T_DAT = 5'b00100;
  localparam T_END = 5'b01000;
  localparam T_FIN = 5'b10000;
  localparam integer HB_CYC_I = `HB_CYC;
  localparam [4:0] HB_LOAD = HB_CYC_I[4:0];

  function [4:0] dec5;
    input [4:0] s;
    begin
      case (s)
        5'h1e: dec5 = 5'h10;
        5'h09: dec5 = 5'h11;
        5'h14: dec5 = 5'h12;
        5'h15: dec5 = 5'h13;
        5'h0a: dec5 = 5'h14;
        5'h0b: dec5 = 5'h15;
        5'h0e: dec5 = 5'h16;
        5'h0f: dec5 = 5'h17;
        5'h12: dec5 = 5'h18;
        5'h13: dec5 = 5'h19;
        5'h16: dec5 = 5'h1a;
        5'h17: dec5 = 5'h1b;
        5'h1a: dec5 = 5'h1c;
        5'h1b: dec5 = 5'h1d;
        5'h1c: dec5 = 5'h1e;
        5'h1d: dec5 = 5'h1f;
        `SYM_J: dec5 = {1'b1, `NIB_PRE};
        `SYM_K: dec5 = {1'b1, `NIB_PRE};
        default: dec5 = 5'h00;
      endcase
    end
  endfunction

  // Missing high bits of a partial nibble read as ones.
  function [3:0] pad_nib;
    input [3:0] n;
    input [2:0] b;
    begin
      case (b)
        3'h1: pad_nib = n | 4'he;
        3'h2: pad_nib = n | 4'hc;
        3'h3: pad_nib = n | 4'h8;
        default: pad_nib = n;
      endcase
    end
  endfunction

  wire [22:0] async_in = {rx_clk, tx_clk, tx_en, txd, rx_sym, rx10_act, rx10_nib,
    rx10_drib, lp_pulse, lp_inv, eof_inv};
  reg [22:0] meta_q;
  reg [22:0] sync_q;
  reg rxc_q, txc_q, lp_q, act_q, txen_q;
  reg [31:0] cfg_q;
  reg link_ll_q;
  reg [3:0] st_q;
  reg [4:0] st10_q;
  reg [4:0] prev_sym_q;
  reg [3:0] prev_nib_q;
  reg pad_q;
  reg [3:0] idle_run_q, inv_run_q;
  reg seen_q, locked_q, link100_q, link10_q, pol10_q;
  reg [21:0] win_cnt_q, lock_cnt_q, sil_cnt_q, lp_cnt_q;
  reg [3:0] lp_inv_q;
  reg [2:0] eof_inv_q;
  reg jab_q;
  reg [16:0] jab_cnt_q;
  reg [4:0] hb_cnt_q;

  wire rxc_s = sync_q[22];
  wire txc_s = sync_q[21];
  wire txen_s = sync_q[20];
  wire [3:0] txd_s = sync_q[19:16];
  wire [4:0] raw_sym = sync_q[15:11];
  wire act_s = sync_q[10];
  wire [3:0] nib_s = sync_q[9:6];
  wire [2:0] drib_s = sync_q[5:3];
  wire lp_s = sync_q[2];
  wire lpinv_s = sync_q[1];
  wire eofinv_s = sync_q[0];
  wire rx_tick = rxc_s & ~rxc_q;
  wire tx_tick = txc_s & ~txc_q;
  wire lp_rise = lp_s & ~lp_q;
  wire an_en = cfg_q[`CFG_AN_EN];
  wire spd100 = an_en ? an_speed100 : cfg_q[`CFG_SPD100];
  wire loop10 = cfg_q[`CFG_LOOP] & ~spd100;
  wire [4:0] sym = raw_sym ^ {5{pol_fix100}};
  wire [4:0] dprev = dec5(prev_sym_q);
  wire link_now = spd100 ? link100_q : link10_q;
  wire link_fail = link_up & ~link_now;
  wire acc = psel & penable & pready;
  wire rd_stat = acc & ~pwrite & (paddr == `ADDR_STAT);
  wire win_end = (win_cnt_q == WIN_CYC - 1);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 23'h000000;
      sync_q <= 23'h000000;
      rxc_q <= 1'b0;
      txc_q <= 1'b0;
      lp_q <= 1'b0;
      act_q <= 1'b0;
      txen_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      rxc_q <= rxc_s;
      txc_q <= txc_s;
      lp_q <= lp_s;
      if (rx_tick)
        act_q <= act_s;
      if (tx_tick)
        txen_q <= txen_s;
    end
  end

  // Register slave: no wait state, so pready rises in the access phase.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= `CFG_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      link_ll_q <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable & ~pready)
      begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        case (paddr)
          `ADDR_CFG: prdata <= cfg_q;
          `ADDR_STAT: prdata <= {27'h0000000, locked_q, jab_q, link_ll_q, pol10_q,
            pol_fix100};
          `ADDR_STAT2: prdata <= {17'h00000, spd100, 3'h0, link_up, an_full_duplex,
            1'b0, an_complete, 7'h00};
          default: pslverr <= 1'b1;
        endcase
      end
      if (acc & pwrite & (paddr == `ADDR_CFG))
        cfg_q <= pwdata;
      // A failure in the read cycle wins over the re-arm.
      if (link_fail)
        link_ll_q <= 1'b0;
      else if (rd_stat)
        link_ll_q <= link_now;
    end
  end

  // 100M lock, polarity and link qualification.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_run_q <= 4'h0;
      inv_run_q <= 4'h0;
      seen_q <= 1'b0;
      locked_q <= 1'b0;
      win_cnt_q <= 22'h000000;
      lock_cnt_q <= 22'h000000;
      link100_q <= 1'b0;
      pol_fix100 <= 1'b0;
    end
    else if (!spd100)
    begin
      seen_q <= 1'b0;
      locked_q <= 1'b0;
      link100_q <= 1'b0;
      lock_cnt_q <= 22'h000000;
      win_cnt_q <= 22'h000000;
    end
    else
    begin
      if (rx_tick)
      begin
        if (sym == `SYM_IDLE)
        begin
          if (idle_run_q != `IDLE_RUN)
            idle_run_q <= idle_run_q + 4'h1;
          // A run that goes on past twelve still counts in every later window.
          if (idle_run_q >= `IDLE_RUN - 1)
          begin
            seen_q <= 1'b1;
            locked_q <= 1'b1;
          end
        end
        else
          idle_run_q <= 4'h0;
        if (sym == ~`SYM_IDLE & ~locked_q)
        begin
          inv_run_q <= (inv_run_q == `IDLE_RUN - 1) ? 4'h0 : inv_run_q + 4'h1;
          if (inv_run_q == `IDLE_RUN - 1)
            pol_fix100 <= ~pol_fix100;
        end
        else
          inv_run_q <= 4'h0;
      end
      win_cnt_q <= win_end ? 22'h000000 : win_cnt_q + 22'h000001;
      if (win_end)
      begin
        locked_q <= seen_q;
        seen_q <= 1'b0;
      end
      if (!locked_q)
      begin
        lock_cnt_q <= 22'h000000;
        link100_q <= 1'b0;
      end
      else if (lock_cnt_q != LOCK_CYC - 1)
        lock_cnt_q <= lock_cnt_q + 22'h000001;
      else
        link100_q <= 1'b1;
    end
  end

  // 10M link integrity and polarity; only link pulses and 10M data feed it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link10_q <= 1'b0;
      lp_cnt_q <= 22'h000000;
      sil_cnt_q <= 22'h000000;
      pol10_q <= 1'b0;
      lp_inv_q <= 4'h0;
      eof_inv_q <= 3'h0;
    end
    else if (spd100)
    begin
      link10_q <= 1'b0;
      lp_cnt_q <= 22'h000000;
    end
    else
    begin
      if (lp_rise | act_s)
        lp_cnt_q <= 22'h000000;
      else if (lp_cnt_q != LP_TO_CYC - 1)
        lp_cnt_q <= lp_cnt_q + 22'h000001;
      if (lp_rise)
        link10_q <= 1'b1;
      else if (lp_cnt_q == LP_TO_CYC - 1)
        link10_q <= 1'b0;
      if (lp_rise | act_s)
        sil_cnt_q <= 22'h000000;
      else if (sil_cnt_q != SIL_CYC - 1)
        sil_cnt_q <= sil_cnt_q + 22'h000001;
      else
        pol10_q <= 1'b0;
      if (lp_rise)
      begin
        lp_inv_q <= lpinv_s ? lp_inv_q + 4'h1 : 4'h0;
        if (lpinv_s & (lp_inv_q == `LP_INV_RUN - 1))
          pol10_q <= 1'b1;
      end
      if (rx_tick & act_q & ~act_s)
      begin
        eof_inv_q <= eofinv_s ? eof_inv_q + 3'h1 : 3'h0;
        if (eofinv_s & (eof_inv_q == `EOF_INV_RUN - 1))
          pol10_q <= 1'b1;
      end
    end
  end

  // Receive framing to the MAC, updated once per receive clock, or once per transmit clock in loopback.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= S_IDLE;
      st10_q <= T_IDLE;
      prev_sym_q <= `SYM_IDLE;
      prev_nib_q <= 4'h0;
      pad_q <= 1'b0;
      crs <= 1'b0;
      rx_dv <= 1'b0;
      rxd <= 4'h0;
      rx_er <= 1'b0;
    end
    else if (loop10)
    begin
      st_q <= S_IDLE;
      st10_q <= T_IDLE;
      if (tx_tick)
      begin
        crs <= txen_s & ~jab_q;
        rx_dv <= txen_s & ~jab_q;
        rxd <= txd_s;
        rx_er <= 1'b0;
      end
    end
    else if (rx_tick & spd100)
    begin
      prev_sym_q <= sym;
      rx_er <= 1'b0;
      st10_q <= T_IDLE;
      case (st_q)
        S_IDLE:
        begin
          crs <= 1'b0;
          rx_dv <= 1'b0;
          rxd <= 4'h0;
          if (sym == `SYM_J)
            st_q <= S_J;
        end
        S_J:
        begin
          if (sym == `SYM_K)
          begin
            st_q <= S_FRM;
            crs <= 1'b1;
            rx_dv <= 1'b1;
            rxd <= `NIB_PRE;
          end
          else
            st_q <= S_IDLE;
        end
        S_FRM:
        begin
          if (sym == `SYM_IDLE)
          begin
            st_q <= S_IDLE;
            crs <= 1'b0;
            rx_dv <= 1'b0;
            rxd <= 4'h0;
            rx_er <= 1'b1;
          end
          else
          begin
            if (sym == `SYM_T)
              st_q <= S_T;
            rx_dv <= 1'b1;
            rxd <= dprev[4] ? dprev[3:0] : 4'h0;
            rx_er <= ~dprev[4];
          end
        end
        S_T:
        begin
          if (sym == `SYM_R | sym == `SYM_IDLE)
          begin
            st_q <= S_IDLE;
            crs <= 1'b0;
            rx_dv <= 1'b0;
            rxd <= 4'h0;
            rx_er <= (sym == `SYM_IDLE);
          end
          else
          begin
            st_q <= S_FRM;
            rx_er <= 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
    else if (rx_tick)
    begin
      st_q <= S_IDLE;
      prev_nib_q <= nib_s;
      case (st10_q)
        T_IDLE:
        begin
          crs <= 1'b0;
          rx_dv <= 1'b0;
          rxd <= 4'h0;
          if (act_s)
            st10_q <= cfg_q[`CFG_PRE_PASS] ? T_DAT : T_PRE;
        end
        T_PRE:
        begin
          if (!act_s)
            st10_q <= T_IDLE;
          else if (nib_s == `NIB_SFD & prev_nib_q == `NIB_PRE)
          begin
            st10_q <= T_DAT;
            crs <= 1'b1;
            rx_dv <= 1'b1;
            rxd <= `NIB_PRE;
          end
        end
        T_DAT:
        begin
          crs <= act_s | cfg_q[`CFG_CRS_SYNC];
          rx_dv <= 1'b1;
          rxd <= prev_nib_q;
          if (!act_s)
          begin
            st10_q <= T_END;
            prev_nib_q <= pad_nib(nib_s, drib_s);
            pad_q <= (drib_s != 3'h0) & (drib_s < 3'h5);
          end
        end
        T_END:
        begin
          st10_q <= pad_q ? T_FIN : T_IDLE;
          rx_dv <= pad_q;
          crs <= pad_q & cfg_q[`CFG_CRS_SYNC];
          rxd <= pad_q ? prev_nib_q : 4'h0;
        end
        T_FIN:
        begin
          st10_q <= T_IDLE;
          crs <= 1'b0;
          rx_dv <= 1'b0;
          rxd <= 4'h0;
        end
        default: st10_q <= T_IDLE;
      endcase
    end
  end

  // Transmit side: jabber, heartbeat and line control.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      jab_q <= 1'b0;
      jab_cnt_q <= 17'h00000;
      hb_cnt_q <= 5'h00;
      col <= 1'b0;
      tx_data_en <= 1'b0;
      flp_send <= 1'b0;
      lp_send <= 1'b0;
      scr_en <= 1'b0;
      scr_seed <= 11'h000;
      link_up <= 1'b0;
      an_restart <= 1'b0;
    end
    else
    begin
      if (spd100 | cfg_q[`CFG_JAB_DIS])
      begin
        jab_q <= 1'b0;
        jab_cnt_q <= 17'h00000;
      end
      else if (tx_tick)
      begin
        if (!jab_q)
        begin
          jab_cnt_q <= txen_s ? jab_cnt_q + 17'h00001 : 17'h00000;
          if (txen_s & (jab_cnt_q == JAB_TX - 1))
          begin
            jab_q <= 1'b1;
            jab_cnt_q <= 17'h00000;
          end
        end
        else if (txen_s)
          jab_cnt_q <= 17'h00000;
        else if (jab_cnt_q == UNJAB_TX - 1)
          jab_q <= 1'b0;
        else
          jab_cnt_q <= jab_cnt_q + 17'h00001;
      end
      if (tx_tick & txen_q & ~txen_s & ~spd100 & cfg_q[`CFG_SQE_EN] & ~jab_q)
        hb_cnt_q <= HB_LOAD;
      else if (hb_cnt_q != 5'h00)
        hb_cnt_q <= hb_cnt_q - 5'h01;
      col <= (hb_cnt_q != 5'h00);
      tx_data_en <= (link_now | (cfg_q[`CFG_OVR] & ~an_en)) & ~jab_q;
      flp_send <= an_en & ~link_now;
      lp_send <= ~spd100 & ~txen_s & ~(an_en & ~link_now);
      scr_en <= spd100 & ~cfg_q[`CFG_SCR_BYP];
      scr_seed <= {`SEED_FIX, cfg_q[`CFG_ADDR_LSB +: 5]};
      link_up <= link_now;
      an_restart <= link_fail & an_en;
    end
  end
endmodule // phy_link_carrier_control

// ---- shared/phy_link_map.vh ----
`ifndef PHY_LINK_MAP_VH
`define PHY_LINK_MAP_VH
// Clock and time figures.
`define CLK_HZ 20000000
`define CLK_NS 50
`define LOCK_MS 50
`define WIN_MS 2
`define SIL_MS 96
`define LP_TO_MS 150
`define HB_NS 1000
`define HB_CYC ((`HB_NS + `CLK_NS - 1) / `CLK_NS)
`define IDLE_RUN 12
`define LP_INV_RUN 8
`define EOF_INV_RUN 4
`define JAB_TX_DEF 25000
`define UNJAB_TX_DEF 100000
// Register byte offsets.
`define ADDR_CFG 8'h00
`define ADDR_STAT 8'h04
`define ADDR_STAT2 8'h08
// Configuration fields.
`define CFG_RST 32'h00000001
`define CFG_AN_EN 0
`define CFG_SPD100 1
`define CFG_LOOP 2
`define CFG_PRE_PASS 5
`define CFG_CRS_SYNC 7
`define CFG_SQE_EN 9
`define CFG_JAB_DIS 10
`define CFG_SCR_BYP 12
`define CFG_OVR 14
`define CFG_ADDR_LSB 16
// Status fields.
`define ST_POL100 0
`define ST_POL10 1
`define ST_LINK_LL 2
`define ST_JAB 3
`define ST_LOCK 4
`define ST2_AN_DONE 7
`define ST2_DUPLEX 9
`define ST2_LINK 10
`define ST2_SPEED 14
// Scrambler seed and code groups.
`define SEED_FIX 6'h2d
`define SYM_IDLE 5'h1f
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_T 5'h0d
`define SYM_R 5'h07
`define NIB_PRE 4'h5
`define NIB_SFD 4'hd
`endif

// ---- tb/mac_model.sv ----
module mac_model (
  // Clock and MII transmit side.
  input wire pclk,
  output logic tx_clk,
  output logic tx_en,
  output logic [3:0] txd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    tx_clk = 1'b0;
    tx_en = 1'b0;
    txd = 4'h0;
    #131;
    forever #200 tx_clk = ~tx_clk;
  end
  // Nibbles change half a period away from the edge the block samples on.
  task automatic send(input logic [3:0] q[$]);
    foreach (q[i])
    begin
      @(negedge tx_clk);
      @(posedge pclk);
      tx_en <= 1'b1;
      txd <= q[i];
    end
    @(negedge tx_clk);
    @(posedge pclk);
    tx_en <= 1'b0;
    // A released data line must not look like a held nibble.
    txd <= ~txd;
  endtask
endmodule // mac_model

// ---- tb/phy_link_carrier_control_asserts.sv ----
`include "phy_link_map.vh"
module phy_link_carrier_control_asserts (
  // Clock, reset and APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Link and MII.
  input wire an_speed100,
  input wire crs,
  input wire rx_dv,
  input wire [3:0] rxd,
  input wire rx_er,
  input wire col,
  input wire tx_data_en,
  input wire flp_send,
  input wire scr_en,
  input wire link_up,
  input wire an_restart
);
  // The configuration is shadowed from completed writes, as only ports are visible.
  logic [31:0] cfg_q;
  logic [7:0] col_n_q;
  logic mode_ok;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cfg_q <= `CFG_RST;
    else if (psel && penable && pready && pwrite && paddr == `ADDR_CFG)
      cfg_q <= pwdata;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      col_n_q <= 8'h00;
    else
      col_n_q <= col ? col_n_q + 8'h01 : 8'h00;
  assign mode_ok = (cfg_q[`CFG_AN_EN] ? an_speed100 : cfg_q[`CFG_SPD100]) && !cfg_q[`CFG_SCR_BYP];
  a_tx_gate: assert property (
    tx_data_en |-> link_up || $past(link_up) || cfg_q[`CFG_OVR] || $past(cfg_q[`CFG_OVR]))
    else $error("transmit allowed without link or override");
  a_flp_down: assert property (
    (cfg_q[`CFG_AN_EN] && !link_up) [*3] |-> flp_send) else $error("no fast link pulses");
  a_scr_mode: assert property (
    mode_ok == $past(mode_ok) && mode_ok == $past(mode_ok, 2) |-> scr_en == mode_ok)
    else $error("scrambler enable wrong for mode");
  a_restart_pulse: assert property (
    an_restart |-> cfg_q[`CFG_AN_EN] ##1 !an_restart) else $error("bad negotiation restart");
  a_rxer_len: assert property (
    $rose(rx_er) |=> rx_er [*6] ##[1:4] !rx_er) else $error("rx error length wrong");
  a_rxer_cause: assert property (
    $rose(rx_er) |-> rx_dv || !crs) else $error("rx error with carrier but no data valid");
  a_err_zero: assert property (
    rx_er && rx_dv |-> rxd == 4'h0) else $error("undecoded nibble not zero");
  a_col_len: assert property (
    $fell(col) |-> col_n_q == `HB_CYC) else $error("heartbeat length wrong");
  a_col_enable: assert property (
    $rose(col) |-> cfg_q[`CFG_SQE_EN]) else $error("heartbeat while disabled");
  cover property ($rose(link_up));
  cover property ($rose(rx_er));
  cover property ($fell(col));
endmodule // phy_link_carrier_control_asserts
bind phy_link_carrier_control phy_link_carrier_control_asserts u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .an_speed100, .crs, .rx_dv, .rxd, .rx_er, .col,
  .tx_data_en, .flp_send, .scr_en, .link_up, .an_restart);

// ---- tb/phy_link_carrier_control_tb.sv ----
`include "phy_link_map.vh"
module phy_link_carrier_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic an_complete = 1'b0, an_speed100 = 1'b0, an_full_duplex = 1'b0, rx_clk = 1'b0;
  logic lp_pulse = 1'b0, lp_inv = 1'b0, mon_tx = 1'b0, er, pready, pslverr, crs, rx_dv;
  logic rx_er, col, tx_data_en, flp_send, lp_send, scr_en, link_up, an_restart, pol_fix100;
  logic tx_clk, tx_en;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] rx_sym = 5'h0e, a5;
  logic [3:0] rxd, txd, d, exp_q[$], got_q[$];
  logic [10:0] scr_seed;
  logic rx10_act = 1'b0, eof_inv = 1'b0;
  logic [3:0] rx10_nib = 4'h0;
  logic [2:0] rx10_drib = 3'h0;
  int error_cnt = 0, cmp_count = 0, seed = 32'h13446c25, er_n = 0, col_n = 0;
  logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12,
    5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic [4:0] ab[7] = '{`SYM_J, `SYM_K, 5'h15, 5'h00, 5'h0b, 5'h0b, `SYM_IDLE};
  phy_link_carrier_control #(.LOCK_CYC(200), .WIN_CYC(400), .SIL_CYC(500), .LP_TO_CYC(500),
    .JAB_TX(20), .UNJAB_TX(20)) u_dut (.*);
  mac_model u_mac (.pclk(pclk), .tx_clk(tx_clk), .tx_en(tx_en), .txd(txd));
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    #73;
    forever #200 rx_clk = ~rx_clk;
  end
  always @(posedge rx_clk)
  begin
    if (!mon_tx && rx_dv === 1'b1) got_q.push_back(rxd);
    if (rx_er === 1'b1) er_n++;
  end
  always @(posedge tx_clk)
    if (mon_tx && rx_dv === 1'b1) got_q.push_back(rxd);
  always @(posedge pclk)
    if (col === 1'b1) col_n++;
  task automatic chk(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic chk_q(input string m);
    chk(got_q.size(), exp_q.size(), m);
    foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i], m);
    got_q = {};
    exp_q = {};
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic sym(input logic [4:0] s);
    @(negedge rx_clk);
    @(posedge pclk);
    rx_sym <= s;
  endtask
  task automatic nib10(input logic a, input logic [3:0] n, input logic [2:0] b);
    @(negedge rx_clk);
    @(posedge pclk);
    rx10_act <= a;
    rx10_nib <= n;
    rx10_drib <= b;
    eof_inv <= 1'($random(seed));
  endtask
  task automatic pulse(input logic inv);
    lp_pulse <= 1'b1;
    lp_inv <= inv;
    cyc(4);
    lp_pulse <= 1'b0;
    cyc(60);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, input string m);
    int n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk(s, v, m);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #2000000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
    apb(0, `ADDR_CFG, 0);
    chk(rd, `CFG_RST, "config reset value");
    apb(0, 8'h40, 0);
    chk(er, 1, "unmapped access");
    repeat (4)
    begin
      {an_complete, an_speed100, an_full_duplex} <= 3'($random(seed));
      cyc(2);
      apb(0, `ADDR_STAT2, 0);
      chk({rd[`ST2_AN_DONE], rd[`ST2_SPEED], rd[`ST2_DUPLEX]},
        {an_complete, an_speed100, an_full_duplex}, "negotiation status");
    end
    apb(1, `ADDR_CFG, 0);
    cyc(3);
    repeat (4)
    begin
      a5 = 5'($random(seed));
      apb(1, `ADDR_CFG, 32'(a5) << `CFG_ADDR_LSB);
      cyc(3);
      chk(scr_seed, {`SEED_FIX, a5}, "seed address bits");
    end
    $display("test registers done");
    apb(1, `ADDR_CFG, 32'h1 << `CFG_SPD100);
    repeat (20) sym(`SYM_IDLE);
    chk(link_up, 0, "link before hold time");
    wait_for(link_up, 1, 1000, "link up");
    chk(tx_data_en, 1, "transmit with link");
    got_q = {};
    exp_q = '{`NIB_PRE, `NIB_PRE};
    sym(`SYM_J);
    sym(`SYM_K);
    repeat (8)
    begin
      d = 4'($random(seed));
      exp_q.push_back(d);
      sym(enc[d]);
    end
    chk(crs, 1, "carrier in frame");
    sym(`SYM_T);
    sym(`SYM_R);
    repeat (4) sym(`SYM_IDLE);
    chk_q("received stream");
    chk(crs, 0, "carrier after end");
    er_n = 0;
    foreach (ab[i]) sym(ab[i]);
    repeat (4) sym(`SYM_IDLE);
    chk(er_n, 2, "receive error pulses");
    chk(crs, 0, "carrier after idle abort");
    got_q = {};
    repeat (120) sym(enc[6]);
    chk(link_up, 0, "link drop without idles");
    chk(tx_data_en, 0, "no transmit without link");
    repeat (20) sym(`SYM_IDLE);
    wait_for(link_up, 1, 1000, "link back");
    apb(0, `ADDR_STAT, 0);
    chk(rd[`ST_LINK_LL], 0, "latched failure");
    apb(0, `ADDR_STAT, 0);
    chk(rd[`ST_LINK_LL] & rd[`ST_LOCK], 1, "live link after read");
    apb(0, `ADDR_STAT2, 0);
    chk(rd[`ST2_LINK], 1, "live link status");
    $display("test fast receive done");
    an_speed100 <= 1'b0;
    apb(1, `ADDR_CFG, `CFG_RST);
    cyc(300);
    chk(link_up, 0, "idles give no slow link");
    repeat (10) pulse(0);
    wait_for(tx_data_en, 1, 100, "slow transmit enable");
    repeat (8) pulse(1);
    apb(0, `ADDR_STAT, 0);
    chk(rd[`ST_POL10], 1, "slow polarity flag");
    wait_for(an_restart, 1, 1000, "renegotiation");
    cyc(2);
    chk(tx_data_en, 0, "transmit off after pulses stop");
    $display("test link pulses done");
    got_q = {};
    exp_q = '{`NIB_PRE, `NIB_SFD};
    repeat (3) nib10(1, `NIB_PRE, 3'h0);
    nib10(1, `NIB_SFD, 3'h0);
    repeat (4)
    begin
      d = 4'($random(seed));
      exp_q.push_back(d);
      nib10(1, d, 3'h0);
    end
    // Two dribble bits: the missing high bits of the last nibble read as ones.
    exp_q.push_back(4'h3 | 4'hc);
    nib10(0, 4'h3, 3'h2);
    repeat (4) nib10(0, 4'h0, 3'h0);
    chk_q("slow receive stream");
    chk(crs, 0, "slow carrier after end");
    $display("test slow receive done");
    mon_tx = 1'b1;
    apb(1, `ADDR_CFG, 32'h00004204);
    exp_q = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'hd};
    repeat (6) exp_q.push_back(4'($random(seed)));
    col_n = 0;
    u_mac.send(exp_q);
    cyc(100);
    chk_q("loopback stream");
    chk(col_n, `HB_CYC, "heartbeat length");
    repeat (30) exp_q.push_back(4'h5);
    u_mac.send(exp_q);
    exp_q = {};
    apb(0, `ADDR_STAT, 0);
    chk(rd[`ST_JAB], 1, "jabber set");
    chk(got_q.size() < 30, 1, "loopback cut by jabber");
    cyc(300);
    apb(0, `ADDR_STAT, 0);
    chk(rd[`ST_JAB], 0, "jabber cleared");
    $display("test loopback done");
    end_of_test();
  end
endmodule // phy_link_carrier_control_tb
